// ==== src/dac_link_defines.svh ====
// Constants for the converter serial load link
`ifndef DAC_LINK_DEFINES_SVH
`define DAC_LINK_DEFINES_SVH

// ----------------------------------------
// Word format
// ----------------------------------------
`define DAC_WORD_BITS 16
`define DAC_CNT_BITS 5
`define DAC_CNT_MAX 5'h1F
`define DAC_RESET_CODE 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define DAC_CLK_PERIOD_NS 8
`define DAC_SCLK_PERIOD_NS 48
`define DAC_SCLK_HALF_CYC (`DAC_SCLK_PERIOD_NS / (2 * `DAC_CLK_PERIOD_NS))
`define DAC_STROBE_NS 20
`define DAC_STROBE_CYC ((`DAC_STROBE_NS + `DAC_CLK_PERIOD_NS - 1) / `DAC_CLK_PERIOD_NS)

`endif

// ==== src/dac_link_pkg.sv ====
// Host sequencer state type and word padding for the converter link, used only by the host end
package dac_link_pkg;

   // ----------------------------------------
   // Host sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_SHIFT = 3'b010,
      ST_CLOSE = 3'b011,
      ST_STROBE = 3'b100,
      ST_GAP = 3'b101
   } host_state_t;

   // ----------------------------------------
   // Left-justify narrow data, zeros below
   // ----------------------------------------
   function automatic logic [15:0] pad_word(input logic [15:0] data, input logic [4:0] width);
      logic [4:0] sh;
      sh = 5'h00;
      if ((width != 5'h00) && (width < 5'h10)) begin
         sh = 5'h10 - width;
      end
      return data << sh;
   endfunction : pad_word

endpackage : dac_link_pkg

// ==== src/dac_link_if.sv ====
// Serial link between host and converter load logic
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
   logic sclk;
   logic sdata;
   logic frame_n;
   logic load_strobe_n;

   modport host (
      output sclk,
      output sdata,
      output frame_n,
      output load_strobe_n
   );

   modport device (
      input sclk,
      input sdata,
      input frame_n,
      input load_strobe_n
   );
endinterface : dac_link_if
`default_nettype wire

// ==== src/dac_load_device.sv ====
// Converter load logic: serial input register and converter register
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_defines.svh"
module dac_load_device
   import dac_link_pkg::*;
(
   // System clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Serial link
   dac_link_if.device link,
   // Converter side
   output logic [15:0] dac_code_out,
   output logic update_out,
   output logic frame_active_out,
   output logic [4:0] frame_len_out,
   output logic short_frame_out
);

   // ----------------------------------------
   // Link-clock domain state
   // ----------------------------------------
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic [4:0] last_len_r;
   logic [4:0] last_len_nxt;

   // ----------------------------------------
   // System-clock domain state
   // ----------------------------------------
   logic frame_s1_r;
   logic frame_s2_r;
   logic frame_d_r;
   logic strobe_s1_r;
   logic strobe_s2_r;
   logic strobe_d_r;
   logic [15:0] dac_r;
   logic [15:0] dac_nxt;
   logic upd_r;
   logic upd_nxt;
   logic act_r;
   logic act_nxt;
   logic [4:0] len_r;
   logic [4:0] len_nxt;
   logic short_r;
   logic short_nxt;
   logic frame_rise;
   logic strobe_fall;
   logic word_full;

   // ----------------------------------------
   // Serial input register
   // ----------------------------------------
   always_comb begin
      shift_nxt = shift_r;
      last_len_nxt = last_len_r;
      cnt_nxt = cnt_r;
      if (!link.frame_n) begin
         shift_nxt = {shift_r[14:0], link.sdata};
         if (cnt_r != `DAC_CNT_MAX) begin
            cnt_nxt = cnt_r + 5'h01;
         end
         last_len_nxt = cnt_nxt;
      end
   end

   // No reset: contents undefined until shifted
   always_ff @(posedge link.sclk) begin
      shift_r <= shift_nxt;
      last_len_r <= last_len_nxt;
   end

   // Bit count restarts whenever the frame closes
   always_ff @(posedge link.sclk or posedge link.frame_n) begin
      if (link.frame_n) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ----------------------------------------
   // Link control synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         frame_s1_r <= 1'b1;
         frame_s2_r <= 1'b1;
         frame_d_r <= 1'b1;
         strobe_s1_r <= 1'b1;
         strobe_s2_r <= 1'b1;
         strobe_d_r <= 1'b1;
      end else if (ce_in) begin
         frame_s1_r <= link.frame_n;
         frame_s2_r <= frame_s1_r;
         frame_d_r <= frame_s2_r;
         strobe_s1_r <= link.load_strobe_n;
         strobe_s2_r <= strobe_s1_r;
         strobe_d_r <= strobe_s2_r;
      end
   end

   assign frame_rise = frame_s2_r & ~frame_d_r;
   assign strobe_fall = ~strobe_s2_r & strobe_d_r;

   // ----------------------------------------
   // Converter register transfer
   // ----------------------------------------
   always_comb begin
      dac_nxt = dac_r;
      upd_nxt = 1'b0;
      len_nxt = len_r;
      short_nxt = short_r;
      act_nxt = ~frame_s2_r;
      word_full = (len_r >= 5'h10);
      if (frame_rise) begin
         len_nxt = last_len_r;
         short_nxt = (last_len_r < 5'h10);
         word_full = (last_len_r >= 5'h10);
         if (!strobe_s2_r) begin
            dac_nxt = shift_r;
            upd_nxt = 1'b1;
         end
      end else if (strobe_fall && frame_s2_r && word_full) begin
         dac_nxt = shift_r;
         upd_nxt = 1'b1;
      end
   end

   // Only a transfer or power reset moves the code
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dac_r <= `DAC_RESET_CODE;
         upd_r <= 1'b0;
         act_r <= 1'b0;
         len_r <= 5'h00;
         short_r <= 1'b0;
      end else if (ce_in) begin
         dac_r <= dac_nxt;
         upd_r <= upd_nxt;
         act_r <= act_nxt;
         len_r <= len_nxt;
         short_r <= short_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign dac_code_out = dac_r;
   assign update_out = upd_r;
   assign frame_active_out = act_r;
   assign frame_len_out = len_r;
   assign short_frame_out = short_r;

endmodule : dac_load_device
`default_nettype wire

// ==== src/dac_load_host.sv ====
// Host end: drives a sixteen-bit frame and load strobe on the link
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_defines.svh"
module dac_load_host
   import dac_link_pkg::*;
(
   // System clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Requests
   input wire logic start_in,
   input wire logic [15:0] data_in,
   input wire logic [4:0] width_in,
   input wire logic defer_in,
   input wire logic strobe_in,
   // Serial link
   dac_link_if.host link,
   // Status
   output logic busy_out,
   output logic done_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   host_state_t state_r;
   host_state_t state_nxt;
   logic [2:0] div_r;
   logic [2:0] div_nxt;
   logic [4:0] bit_r;
   logic [4:0] bit_nxt;
   logic [15:0] word_r;
   logic [15:0] word_nxt;
   logic sclk_r;
   logic sclk_nxt;
   logic frame_n_r;
   logic frame_n_nxt;
   logic strobe_n_r;
   logic strobe_n_nxt;
   logic done_r;
   logic done_nxt;
   logic busy_r;
   logic busy_nxt;
   logic tick;

   assign tick = (div_r == 3'(`DAC_SCLK_HALF_CYC - 1));

   always_comb begin
      state_nxt = state_r;
      div_nxt = tick ? 3'h0 : div_r + 3'h1;
      bit_nxt = bit_r;
      word_nxt = word_r;
      sclk_nxt = sclk_r;
      frame_n_nxt = frame_n_r;
      strobe_n_nxt = strobe_n_r;
      done_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            div_nxt = 3'h0;
            if (start_in) begin
               word_nxt = pad_word(data_in, width_in);
               bit_nxt = 5'h00;
               frame_n_nxt = 1'b0;
               strobe_n_nxt = defer_in;
               state_nxt = ST_SETUP;
            end else if (strobe_in) begin
               strobe_n_nxt = 1'b0;
               state_nxt = ST_STROBE;
            end
         end
         ST_SETUP: begin
            if (tick) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (tick) begin
               sclk_nxt = ~sclk_r;
               if (sclk_r) begin
                  word_nxt = {word_r[14:0], 1'b0};
                  bit_nxt = bit_r + 5'h01;
                  if (bit_r == 5'(`DAC_WORD_BITS - 1)) begin
                     state_nxt = ST_CLOSE;
                  end
               end
            end
         end
         ST_CLOSE: begin
            if (tick) begin
               frame_n_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = ST_GAP;
            end
         end
         ST_STROBE: begin
            if (div_r == 3'(`DAC_STROBE_CYC - 1)) begin
               strobe_n_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = ST_GAP;
            end
         end
         ST_GAP: begin
            if (tick) begin
               strobe_n_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            frame_n_nxt = 1'b1;
            strobe_n_nxt = 1'b1;
            sclk_nxt = 1'b0;
         end
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ST_IDLE;
         div_r <= 3'h0;
         bit_r <= 5'h00;
         word_r <= 16'h0000;
         sclk_r <= 1'b0;
         frame_n_r <= 1'b1;
         strobe_n_r <= 1'b1;
         done_r <= 1'b0;
         busy_r <= 1'b0;
      end else if (ce_in) begin
         state_r <= state_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         word_r <= word_nxt;
         sclk_r <= sclk_nxt;
         frame_n_r <= frame_n_nxt;
         strobe_n_r <= strobe_n_nxt;
         done_r <= done_nxt;
         busy_r <= busy_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.sclk = sclk_r;
   assign link.sdata = word_r[15];
   assign link.frame_n = frame_n_r;
   assign link.load_strobe_n = strobe_n_r;
   assign busy_out = busy_r;
   assign done_out = done_r;

endmodule : dac_load_host
`default_nettype wire

// ==== tb/dac_link_checker.sv ====
// Concurrent checks on the converter link and converter code
`timescale 1ns/1ps
`default_nettype none
module dac_link_checker (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Link and converter code
   input wire logic sclk,
   input wire logic sdata,
   input wire logic frame_n,
   input wire logic load_strobe_n,
   input wire logic [15:0] dac_code_out,
   input wire logic update_out
);
   default clocking @(posedge clk_in);
   endclocking
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sclk_burst_a: assert property (disable iff (!rst_b_in) frame_n |-> !sclk)
      else $error("serial clock toggles outside a frame");
   code_change_a: assert property (disable iff (!rst_b_in) $changed(dac_code_out) |-> update_out)
      else $error("code changed without a load");
   frame_load_a: assert property (disable iff (!rst_b_in)
      $rose(frame_n) && !load_strobe_n |-> ##[1:5] update_out)
      else $error("no load at frame end");
   defer_hold_a: assert property (disable iff (!rst_b_in)
      $rose(frame_n) && load_strobe_n |-> !update_out [*4])
      else $error("load at frame end with strobe high");
   strobe_load_a: assert property (disable iff (!rst_b_in)
      $fell(load_strobe_n) && frame_n |-> ##[1:6] update_out)
      else $error("no load after strobe");
   sdata_stable_a: assert property (disable iff (!rst_b_in) $rose(sclk) |-> $stable(sdata))
      else $error("data moved at sampling edge");
   strobe_width_a: assert property (disable iff (!rst_b_in)
      $fell(load_strobe_n) && frame_n |=> !load_strobe_n [*2])
      else $error("strobe pulse too short");
   update_pulse_a: assert property (disable iff (!rst_b_in) update_out |=> !update_out)
      else $error("load pulse longer than one cycle");
   reset_zero_a: assert property (!rst_b_in |-> dac_code_out == 16'h0000)
      else $error("code not zero in reset");
endmodule : dac_link_checker
`default_nettype wire

// ==== tb/dac_serial_load_logic_tb_top.sv ====
// Testbench joining host and converter ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_logic_tb_top;
   typedef struct {logic [15:0] data; logic [4:0] width; logic defer; logic [15:0] code;} row_t;
   logic clk_in, rst_b_in, start_in, defer_in, strobe_in, busy_out, done_out, update_out, short2;
   logic act2;
   logic [15:0] data_in, dac_code_out, code2;
   logic [4:0] width_in, len2;
   int err_count, compares;
   row_t rows [4] = '{'{16'hA5C3, 5'h00, 1'b0, 16'hA5C3}, '{16'h0ABC, 5'h0C, 1'b0, 16'hABC0},
      '{16'h0001, 5'h01, 1'b0, 16'h8000}, '{16'h1234, 5'h10, 1'b1, 16'h8000}};
   dac_link_if link ();
   dac_link_if link2 ();
   dac_load_host dac_load_host_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
      .start_in(start_in), .data_in(data_in), .width_in(width_in), .defer_in(defer_in),
      .strobe_in(strobe_in), .link(link.host), .busy_out(busy_out), .done_out(done_out));
   dac_load_device dac_load_device_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
      .link(link.device), .dac_code_out(dac_code_out), .update_out(update_out),
      .frame_active_out(), .frame_len_out(), .short_frame_out());
   dac_load_device dac_load_device_i2 (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
      .link(link2.device), .dac_code_out(code2), .update_out(), .frame_active_out(act2),
      .frame_len_out(len2), .short_frame_out(short2));
   dac_link_checker dac_link_checker_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .sclk(link.sclk), .sdata(link.sdata), .frame_n(link.frame_n),
      .load_strobe_n(link.load_strobe_n), .dac_code_out(dac_code_out), .update_out(update_out));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic request(input logic go, input row_t r);
      data_in = r.data;
      width_in = r.width;
      defer_in = r.defer;
      start_in = go;
      strobe_in = !go;
      @(negedge clk_in);
      start_in = 1'b0;
      strobe_in = 1'b0;
      while (done_out !== 1'b1) @(negedge clk_in);
      repeat (12) @(negedge clk_in);
   endtask : request
   task automatic bang(input logic [19:0] bits, input int n);
      link2.frame_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         link2.sdata = bits[i];
         repeat (3) @(negedge clk_in);
         link2.sclk = 1'b1;
         repeat (3) @(negedge clk_in);
         link2.sclk = 1'b0;
      end
      link2.sdata = ~link2.sdata;
      repeat (3) @(negedge clk_in);
      check("active", {15'h0000, act2}, 16'h0001);
      link2.frame_n = 1'b1;
      repeat (12) @(negedge clk_in);
   endtask : bang
   task automatic print_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end
   initial begin
      {start_in, strobe_in, defer_in, data_in, width_in} = '0;
      rst_b_in = 1'b1;
      {link2.sclk, link2.sdata, link2.frame_n, link2.load_strobe_n} = 4'h2;
      err_count = 0;
      compares = 0;
      @(negedge clk_in);
      rst_b_in = 1'b0;
      repeat (16) @(negedge clk_in);
      check("code", dac_code_out, 16'h0000);
      rst_b_in = 1'b1;
      repeat (4) @(negedge clk_in);
      foreach (rows[i]) begin
         request(1'b1, rows[i]);
         check("code", dac_code_out, rows[i].code);
         check("busy", {15'h0000, busy_out}, 16'h0000);
         $display("row %0d done", i);
      end
      request(1'b0, rows[0]);
      check("code", dac_code_out, 16'h1234);
      $display("strobe load done");
      bang(20'hF1234, 20);
      check("long code", code2, 16'h1234);
      check("long len", {11'h000, len2}, 16'h0014);
      bang(20'h0005A, 8);
      check("short code", code2, 16'h345A);
      check("short flag", {15'h0000, short2}, 16'h0001);
      $display("frame length tests done");
      rst_b_in = 1'b0;
      repeat (3) @(negedge clk_in);
      check("code", dac_code_out, 16'h0000);
      rst_b_in = 1'b1;
      repeat (4) @(negedge clk_in);
      check("code", code2, 16'h0000);
      $display("reset test done");
      print_verdict();
   end
endmodule : dac_serial_load_logic_tb_top
`default_nettype wire
